// ### design/freeze_pkg.sv
package freeze_pkg;

	localparam int num_io = 8;
	localparam int data_w = 32;

	// Register byte offsets
	localparam logic [7:0] ctrl_off = 8'h00;
	localparam logic [7:0] status_off = 8'h04;
	localparam logic [7:0] mode_off = 8'h08;
	localparam logic [7:0] io_out_off = 8'h0c;
	localparam logic [7:0] io_oe_off = 8'h10;
	localparam logic [7:0] io_in_off = 8'h14;
	localparam logic [7:0] count_off = 8'h18;

	// Control fields
	localparam int ctrl_pin_en_bit = 0;
	localparam int ctrl_core_route_bit = 1;
	localparam int ctrl_allow_bit = 2;

	// Reset values
	localparam logic [2:0] ctrl_reset = 3'h1;
	localparam logic [15:0] mode_reset = 16'h0000;

	// Entry and exit bound
	localparam int freeze_limit_ns = 1000;
	localparam int clk_period_ns = 5;
	localparam int freeze_limit_cycles = freeze_limit_ns / clk_period_ns;
	// Entry and exit each take this many cycles, well inside the bound
	localparam int transition_cycles = 2;

	typedef enum logic [1:0] {
		hold_state,
		tristate,
		drive_weak,
		drive_fixed
	} io_freeze_mode_t;

	typedef struct packed {
		logic [num_io-1:0] out;
		logic [num_io-1:0] oe;
		logic [num_io-1:0] pull_up;
		logic [num_io-1:0] pull_down;
	} io_pins_t;

	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;

endpackage

// ### design/freeze_sync.sv
`timescale 1ns/1ps
module freeze_sync
	import freeze_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic d,
	output logic q
);
	logic meta;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta <= 1'b1;
			q <= 1'b1;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule // freeze_sync

// ### design/freeze_ctrl.sv
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module freeze_ctrl
	import freeze_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic freeze_n_in,
	output logic freeze_n_out,
	output logic freeze_n_oe,
	output logic core_freeze_req,
	input wire logic core_freeze_ok,
	output logic frozen,
	input wire logic [num_io-1:0] user_out,
	input wire logic [num_io-1:0] user_oe,
	input wire logic [num_io-1:0] io_in,
	output io_pins_t pins,
	output logic core_clk_en
);
	typedef enum logic [1:0] {
		st_active,
		st_entering,
		st_frozen,
		st_exiting
	} fstate_t;

	fstate_t state;
	fstate_t next_state;
	logic [2:0] ctrl;
	logic [15:0] mode;
	logic [num_io-1:0] fixed_lvl;
	// Request pin's own drive when it serves as plain I/O
	logic sw_out;
	logic sw_oe;
	logic [num_io-1:0] in_hold;
	logic [num_io-1:0] held_out;
	logic [num_io-1:0] held_oe;
	logic [15:0] freeze_count;
	logic [1:0] tcount;
	logic req_sync;
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;

	function automatic io_freeze_mode_t mode_of(input logic [15:0] m, input int i);
		return io_freeze_mode_t'(m[2*i +: 2]);
	endfunction

	function automatic logic known_addr(input logic [7:0] a);
		return a == ctrl_off || a == status_off || a == mode_off || a == io_out_off ||
			a == io_oe_off || a == io_in_off || a == count_off;
	endfunction

	// Pin as freeze request, or plain user I/O when freeze is disabled
	wire pin_en = ctrl[ctrl_pin_en_bit];
	wire route_core = ctrl[ctrl_core_route_bit];
	wire sw_allow = ctrl[ctrl_allow_bit];
	wire req_low = pin_en && !req_sync;
	// Core gate only counts when routed; software allow bit covers the direct path
	wire gate_ok = route_core ? core_freeze_ok : sw_allow;
	wire enter_go = req_low && gate_ok;
	wire is_frozen = state == st_frozen || state == st_entering;
	wire tdone = tcount == 2'(transition_cycles - 1);

	// Synchronised copy; the raw pin reaches nothing else
	freeze_sync u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d(freeze_n_in),
		.q(req_sync)
	);

	always_comb begin
		next_state = state;
		case (state)
			st_active: if (enter_go) next_state = st_entering;
			st_entering: if (tdone) next_state = st_frozen;
			st_frozen: if (!req_low) next_state = st_exiting;
			st_exiting: if (tdone) next_state = st_active;
			default: next_state = st_active;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= st_active;
			tcount <= 2'h0;
		end else begin
			state <= next_state;
			tcount <= (next_state != state) ? 2'h0 : tcount + 2'h1;
		end
	end

	// Capture the pin image at entry; it is what the hold mode replays
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			held_out <= '0;
			held_oe <= '0;
		end else if (state == st_active && enter_go) begin
			held_out <= user_out;
			held_oe <= user_oe;
		end
	end

	// Inputs sampled only while running; toggling during freeze is ignored
	always_ff @(posedge aclk) begin
		if (!aresetn)
			in_hold <= '0;
		else if (!is_frozen)
			in_hold <= io_in;
	end

	// Pin drivers, registered so outputs come straight from flip-flops
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pins <= '0;
		end else begin
			for (int i = 0; i < num_io; i++) begin
				if (next_state != st_frozen && next_state != st_entering) begin
					pins.out[i] <= user_out[i];
					pins.oe[i] <= user_oe[i];
					pins.pull_up[i] <= 1'b0;
					pins.pull_down[i] <= 1'b0;
				end else begin
					case (mode_of(mode, i))
						hold_state: begin
							pins.out[i] <= held_out[i];
							pins.oe[i] <= held_oe[i];
							pins.pull_up[i] <= 1'b0;
							pins.pull_down[i] <= 1'b0;
						end
						tristate: begin
							pins.out[i] <= 1'b0;
							pins.oe[i] <= 1'b0;
							pins.pull_up[i] <= 1'b0;
							pins.pull_down[i] <= 1'b0;
						end
						drive_weak: begin
							pins.out[i] <= 1'b0;
							pins.oe[i] <= 1'b0;
							pins.pull_up[i] <= fixed_lvl[i];
							pins.pull_down[i] <= !fixed_lvl[i];
						end
						drive_fixed: begin
							pins.out[i] <= fixed_lvl[i];
							pins.oe[i] <= 1'b1;
							pins.pull_up[i] <= 1'b0;
							pins.pull_down[i] <= 1'b0;
						end
						default: begin
							pins.out[i] <= held_out[i];
							pins.oe[i] <= held_oe[i];
							pins.pull_up[i] <= 1'b0;
							pins.pull_down[i] <= 1'b0;
						end
					endcase
				end
			end
		end
	end

	// Core clock gate stalls every core register and memory without reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			core_clk_en <= 1'b1;
			frozen <= 1'b0;
			core_freeze_req <= 1'b0;
			freeze_n_out <= 1'b0;
			freeze_n_oe <= 1'b0;
			freeze_count <= 16'h0000;
		end else begin
			core_clk_en <= !(next_state == st_entering || next_state == st_frozen);
			frozen <= next_state == st_frozen;
			// Exit reopens the gate only; no reset or reload of core state
			core_freeze_req <= pin_en && route_core && !req_sync;
			freeze_n_out <= sw_out;
			freeze_n_oe <= !pin_en && sw_oe;
			if (state == st_active && next_state == st_entering)
				freeze_count <= freeze_count + 16'h0001;
		end
	end

	// AXI4-Lite slave: address and data taken in either order
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire do_write = aw_held && w_held && !s_axi_bvalid;
	wire wr_known = known_addr(aw_addr);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= resp_okay;
		end else begin
			s_axi_awready <= !aw_held && !aw_take && !s_axi_bvalid;
			s_axi_wready <= !w_held && !w_take && !s_axi_bvalid;
			if (aw_take) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr[7:0];
			end
			if (w_take) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_known ? resp_okay : resp_slverr;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Settings change only while active; a write committing on the edge that enters a freeze still takes effect during it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= ctrl_reset;
			mode <= mode_reset;
			fixed_lvl <= '0;
			sw_out <= 1'b0;
			sw_oe <= 1'b0;
		end else if (do_write && state == st_active) begin
			case (aw_addr)
				ctrl_off: ctrl <= w_data[2:0];
				mode_off: mode <= w_data[15:0];
				io_out_off: fixed_lvl <= w_data[num_io-1:0];
				io_oe_off: begin
					sw_out <= w_data[0];
					sw_oe <= w_data[8];
				end
				default: ;
			endcase
		end
	end

	wire [7:0] rd_addr = s_axi_araddr[7:0];
	wire [31:0] rd_mux =
		rd_addr == ctrl_off ? {29'h0, ctrl} :
		rd_addr == status_off ? {27'h0, req_sync, state == st_frozen, core_clk_en, state} :
		rd_addr == mode_off ? {16'h0, mode} :
		rd_addr == io_out_off ? {24'h0, fixed_lvl} :
		rd_addr == io_oe_off ? {23'h0, sw_oe, 7'h0, sw_out} :
		rd_addr == io_in_off ? {24'h0, in_hold} :
		rd_addr == count_off ? {16'h0, freeze_count} : 32'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= resp_okay;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= known_addr(rd_addr) ? resp_okay : resp_slverr;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule // freeze_ctrl

// ### dv/freeze_ctrl_monitor.sv
`timescale 1ns/1ps
module freeze_ctrl_monitor
	import freeze_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic freeze_n_in,
	input wire logic core_freeze_req,
	input wire logic frozen,
	input wire logic core_clk_en,
	input wire logic s_axi_arready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire io_pins_t pins
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_exit; frozen && freeze_n_in |-> ##[1:200] !frozen; endproperty
	a_exit: assert property (p_exit) else $error("freeze exit too slow");
	property p_entry; $fell(core_clk_en) |-> ##[1:200] frozen; endproperty
	a_entry: assert property (p_entry) else $error("freeze entry too slow");
	property p_gated; frozen |-> !core_clk_en; endproperty
	a_gated: assert property (p_gated) else $error("core clock runs while frozen");
	property p_resume; $fell(frozen) |-> ##[1:8] core_clk_en; endproperty
	a_resume: assert property (p_resume) else $error("core clock not restored");
	property p_retain; frozen && $past(frozen) |-> $stable(pins); endproperty
	a_retain: assert property (p_retain) else $error("pins moved while frozen");
	property p_quiet; freeze_n_in [*8] |-> !core_freeze_req; endproperty
	a_quiet: assert property (p_quiet) else $error("request with pin high");
	property p_bdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
	a_bdone: assert property (p_bdone) else $error("write response repeated");
	property p_rdone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
	a_rdone: assert property (p_rdone) else $error("read response repeated");
	property p_arpulse; s_axi_arready |=> !s_axi_arready; endproperty
	a_arpulse: assert property (p_arpulse) else $error("arready longer than a pulse");
	c_frozen: cover property ($rose(frozen));
	c_req: cover property (core_freeze_req && !frozen);
	c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule // freeze_ctrl_monitor

bind freeze_ctrl freeze_ctrl_monitor mon (.*);

// ### dv/power_mgr.sv
`timescale 1ns/1ps
module power_mgr (
	input wire logic aclk,
	input wire logic want_freeze,
	input wire logic [3:0] lag,
	output logic freeze_n
);
	logic [3:0] cnt = 4'h0;
	initial freeze_n = 1'b1;
	// Pin follows the command after lag cycles, to model a slow controller
	always @(posedge aclk) begin
		cnt <= (want_freeze == freeze_n) ? cnt + 4'h1 : 4'h0;
		if (want_freeze == freeze_n && cnt >= lag) begin
			freeze_n <= !want_freeze;
			cnt <= 4'h0;
		end
	end
endmodule // power_mgr

// ### dv/testbench.sv
`timescale 1ns/1ps
module testbench;
	import freeze_pkg::*;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, freeze_n_in, freeze_n_out, freeze_n_oe;
	logic core_freeze_req, core_freeze_ok, frozen, core_clk_en, want_freeze, pm_level;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0] s_axi_wstrb, lag;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [num_io-1:0] user_out, user_oe, io_in;
	io_pins_t pins;
	int err_count = 0;
	int total_checks = 0;
	logic [31:0] rows [5][4] = '{'{32'(ctrl_off), 32'h5, 32'h5, 32'(resp_okay)},
		'{32'(mode_off), 32'he4, 32'he4, 32'(resp_okay)},
		'{32'(io_out_off), 32'h8, 32'h8, 32'(resp_okay)},
		'{32'(io_oe_off), 32'h101, 32'h101, 32'(resp_okay)},
		'{32'h40, 32'h1, 32'h0, 32'(resp_slverr)}};
	// Pin level resolves from the block's own drive and the controller
	assign freeze_n_in = freeze_n_oe ? freeze_n_out : pm_level;
	freeze_ctrl dut (.*);
	power_mgr pm (.aclk(aclk), .want_freeze(want_freeze), .lag(lag), .freeze_n(pm_level));
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	task automatic close_out();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(inout int n);
		n++;
		if (n > 200) begin
			err_count++;
			close_out();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			tick(n);
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, er);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = resp_okay);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= {24'h0, a};
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			tick(n);
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk({s_axi_rresp, s_axi_rdata}, {er, exp});
	endtask
	task automatic wait_frz(input logic v);
		int n;
		n = 0;
		do begin
			@(posedge aclk);
			tick(n);
		end while (frozen !== v);
	endtask
	initial begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
		s_axi_wstrb = 4'hf;
		{core_freeze_ok, want_freeze, lag, io_in} = 14'h0;
		user_out = 8'h5a;
		user_oe = 8'hff;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (rows[i]) begin
			wr(rows[i][0][7:0], rows[i][1], rows[i][3][1:0]);
			rd(rows[i][0][7:0], rows[i][2], rows[i][3][1:0]);
		end
		// Hold, tristate, weak low, drive high on pins 0 to 3
		want_freeze <= 1'b1;
		wait_frz(1'b1);
		chk({pins.oe, pins.pull_up, pins.pull_down, pins.out & 8'hf9}, 32'hf9000458);
		// Status while frozen: pin low, frozen, core clock off, state code 2
		rd(status_off, 32'ha);
		user_out <= 8'ha5;
		io_in <= 8'hff;
		wr(ctrl_off, 32'h0, resp_okay);
		rd(io_in_off, 32'h0);
		want_freeze <= 1'b0;
		wait_frz(1'b0);
		repeat (4) @(posedge aclk);
		chk({core_clk_en, pins.out}, {1'b1, 8'ha5});
		rd(ctrl_off, 32'h5);
		rd(count_off, 32'h1);
		// Routed request waits for the core gate, with a slow controller
		wr(ctrl_off, 32'h3, resp_okay);
		// Weak pull-up on pin 2, fixed low on pin 3 this time
		wr(io_out_off, 32'h4, resp_okay);
		lag <= 4'h9;
		want_freeze <= 1'b1;
		repeat (30) @(posedge aclk);
		chk({core_freeze_req, frozen}, 2'b10);
		core_freeze_ok <= 1'b1;
		wait_frz(1'b1);
		chk({pins.oe, pins.pull_up, pins.pull_down, pins.out}, 32'hf90400a1);
		want_freeze <= 1'b0;
		wait_frz(1'b0);
		core_freeze_ok <= 1'b0;
		// Allow set but pin disabled, so the freeze stays blocked even once the block's own drive is released and the pin goes low
		wr(ctrl_off, 32'h4, resp_okay);
		wr(io_oe_off, 32'h101, resp_okay);
		want_freeze <= 1'b1;
		repeat (3) @(posedge aclk);
		chk({freeze_n_oe, freeze_n_out, freeze_n_in}, 3'h7);
		wr(io_oe_off, 32'h0, resp_okay);
		repeat (30) @(posedge aclk);
		chk(frozen, 1'b0);
		rd(count_off, 32'h2);
		want_freeze <= 1'b0;
		aresetn <= 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd(ctrl_off, 32'(ctrl_reset));
		rd(count_off, 32'h0);
		chk({frozen, core_clk_en}, 2'b01);
		close_out();
	end
endmodule // testbench
